/* can_bus_node.sv */
`default_nettype none
module can_bus_node (
    // Clock
    input wire logic i_clock,
    // Bus events seen by the controller
    output var can_gen_pkg::bus_event_t o_bus
);
    import can_gen_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // Quiet bus until a frame is asked for
    initial o_bus = '0;
    // One frame: start pulse, busy span, last end bit, optional overload start
    task automatic frame(input int len, input logic ovld);
        @(negedge i_clock);
        o_bus <= '{1'b1, 1'b0, 1'b1, 1'b0};
        repeat (len) @(negedge i_clock) o_bus.sof <= 1'b0;
        o_bus.eof_last <= 1'b1;
        @(negedge i_clock);
        o_bus <= '{1'b0, 1'b0, 1'b0, ovld};
        @(negedge i_clock);
        o_bus <= '0;
    endtask : frame
endmodule : can_bus_node
`default_nettype wire

/* can_gen_cfg.svh */
// What this block does
// - In time-triggered mode, capture-select set captures timer at last EOF bit, else at SOF.
// - Capture-select bit is ignored when time-triggered mode is off.
// - Setting the enable bit enables the controller and ungates its clock.
// - Clearing enable during bus activity lets the current frame finish first.
// - Once disabled, the controller state is frozen.
// - In standby the transmit output is held recessive.
// - In standby the receiver is inactive and the controller clock is stopped.
// - While disabled, registers stay readable and writable.
// - Controller starts running four clock periods after the enable bit is set.
// - Reset clears the whole general control register to zero.
// - A read-only enable flag shows the enable state actually in force.
`ifndef CAN_GEN_CFG_SVH
`define CAN_GEN_CFG_SVH
`define GCON_RESET 8'h00
`define GCON_BIT_ABORT 7
`define GCON_BIT_OVLD 6
`define GCON_BIT_TTC 5
`define GCON_BIT_SYNC 4
`define GCON_BIT_LISTEN 3
`define GCON_BIT_TEST 2
`define GCON_BIT_ENA 1
`define GCON_BIT_CONTROLLER_SOFT_RESET 0
`define ENA_START_CYCLES 2'h2
`endif

/* can_gen_pkg.sv */
`default_nettype none
package can_gen_pkg;
    // Software write of the control register
    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } reg_write_t;
    // Bus status from the protocol engine
    typedef struct packed {
        logic sof;
        logic eof_last;
        logic bus_busy;
        logic ovld_start;
    } bus_event_t;
    // Enable sequencing
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WAKE = 2'b01,
        ST_ON = 2'b11,
        ST_DRAIN = 2'b10
    } ena_state_t;
endpackage : can_gen_pkg
`default_nettype wire

/* can_general_control.sv */
`include "can_gen_cfg.svh"
`default_nettype none
module can_general_control (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Register port
    input wire can_gen_pkg::reg_write_t i_wr,
    output logic [7:0] o_general_control_reg,
    output logic o_enable_state_flag,
    // Protocol engine side
    input wire can_gen_pkg::bus_event_t i_bus,
    input wire logic i_engine_txd,
    output logic o_ctrl_clk_en,
    output logic o_ctrl_run,
    output logic o_rx_enable,
    output logic o_txd,
    output logic o_ctrl_soft_reset,
    output logic o_overload_frame_request,
    output logic o_listen_mode,
    output logic o_tt_capture
);
    import can_gen_pkg::*;

    logic [7:0] gcon_reg;
    ena_state_t state_reg;
    logic [1:0] wake_cnt_reg;
    logic ena_bit;
    logic tt_hit;

    // ON and DRAIN both count as running; decoded in more than one place
    function automatic logic is_running(input ena_state_t s);
        return (s == ST_ON) || (s == ST_DRAIN);
    endfunction : is_running

    assign ena_bit = gcon_reg[`GCON_BIT_ENA];

    // Control register; soft reset and overload request clear themselves
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            gcon_reg <= `GCON_RESET;
        end else begin
            if (i_wr.wr) begin
                gcon_reg <= i_wr.data;
            end else begin
                gcon_reg[`GCON_BIT_CONTROLLER_SOFT_RESET] <= 1'b0;
            end
            // Start of overload frame clears the request, unless rewritten now
            if (i_bus.ovld_start && !(i_wr.wr && i_wr.data[`GCON_BIT_OVLD])) begin
                gcon_reg[`GCON_BIT_OVLD] <= 1'b0;
            end
        end
    end

    // Enable sequencer: wake takes two cycles, drain waits for frame end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= ST_OFF;
            wake_cnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    wake_cnt_reg <= 2'h0;
                    if (ena_bit) begin
                        state_reg <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    wake_cnt_reg <= wake_cnt_reg + 2'h1;
                    if (!ena_bit) begin
                        state_reg <= ST_OFF;
                    end else if (wake_cnt_reg == `ENA_START_CYCLES - 2'h1) begin
                        state_reg <= ST_ON;
                    end
                end
                ST_ON: begin
                    if (!ena_bit) begin
                        state_reg <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (ena_bit) begin
                        state_reg <= ST_ON;
                    end else if (!i_bus.bus_busy) begin
                        state_reg <= ST_OFF;
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // Capture point only matters in time-triggered mode
    assign tt_hit = gcon_reg[`GCON_BIT_TTC] &&
        (gcon_reg[`GCON_BIT_SYNC] ? i_bus.eof_last : i_bus.sof);

    // Readback copy of the control register, one cycle behind the store
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_general_control_reg <= `GCON_RESET;
        end else begin
            o_general_control_reg <= gcon_reg;
        end
    end

    // Enable flag shows the mode in force, not the bit just written
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_enable_state_flag <= 1'b0;
        end else begin
            o_enable_state_flag <= is_running(state_reg);
        end
    end

    // Clock gate opens as soon as the bit is seen, so wake can count
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ctrl_clk_en <= 1'b0;
        end else begin
            o_ctrl_clk_en <= (state_reg != ST_OFF) || ena_bit;
        end
    end

    // Controller runs only once wake is over; frozen when off
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ctrl_run <= 1'b0;
        end else begin
            o_ctrl_run <= is_running(state_reg);
        end
    end

    // Receiver stays off in standby
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rx_enable <= 1'b0;
        end else begin
            o_rx_enable <= (state_reg != ST_OFF);
        end
    end

    // Standby forces recessive; otherwise the engine bit, one cycle late
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_txd <= 1'b1;
        end else begin
            o_txd <= (state_reg == ST_OFF) ? 1'b1 : i_engine_txd;
        end
    end

    // Soft reset pulse lasts as long as the self-clearing bit
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ctrl_soft_reset <= 1'b0;
        end else begin
            o_ctrl_soft_reset <= gcon_reg[`GCON_BIT_CONTROLLER_SOFT_RESET];
        end
    end

    // Overload request stands until the engine reports its start
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_overload_frame_request <= 1'b0;
        end else begin
            o_overload_frame_request <= gcon_reg[`GCON_BIT_OVLD];
        end
    end

    // Listening mode is a plain copy of its bit
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_listen_mode <= 1'b0;
        end else begin
            o_listen_mode <= gcon_reg[`GCON_BIT_LISTEN];
        end
    end

    // Timer capture pulse, one cycle after the chosen frame point
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_tt_capture <= 1'b0;
        end else begin
            o_tt_capture <= tt_hit;
        end
    end

    // Assertions: standby behaviour
    a_standby_tx_recessive: assert property (@(posedge i_clock) disable iff (i_rst)
        $past(state_reg) == ST_OFF |-> o_txd)
        else $error("tx not recessive in standby");

    a_tx_follows_engine: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg != ST_OFF |=> o_txd == $past(i_engine_txd))
        else $error("tx does not follow engine");

    a_clk_stop_standby: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_OFF && !ena_bit |=> !o_ctrl_clk_en)
        else $error("clock runs in standby");

    a_rx_on_active: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg != ST_OFF |=> o_rx_enable)
        else $error("receiver off while active");

    a_run_frozen_off: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_OFF |=> !o_ctrl_run)
        else $error("controller runs while off");

    a_flag_state: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_OFF |=> !o_enable_state_flag && !o_rx_enable)
        else $error("flag on while off");

    // Assertions: enable sequencing
    a_clk_on_enable: assert property (@(posedge i_clock) disable iff (i_rst)
        ena_bit |=> o_ctrl_clk_en)
        else $error("clock gated while enabled");

    a_off_to_wake: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_OFF && ena_bit |=> state_reg == ST_WAKE)
        else $error("enable not taken");

    a_wake_two_cycles: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == ST_OFF && ena_bit) ##1 ena_bit [*2] |=> state_reg == ST_ON)
        else $error("wake delay wrong");

    a_wake_not_early: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_WAKE |=> !o_ctrl_run)
        else $error("controller ran during wake");

    a_on_to_drain: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_ON && !ena_bit |=> state_reg == ST_DRAIN)
        else $error("disable not taken");

    a_drain_holds: assert property (@(posedge i_clock) disable iff (i_rst)
        (state_reg == ST_DRAIN && i_bus.bus_busy && !ena_bit) |=> state_reg == ST_DRAIN)
        else $error("frame cut off");

    a_drain_keeps_run: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_DRAIN |=> o_ctrl_run)
        else $error("controller stopped mid frame");

    a_drain_to_off: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_DRAIN && !ena_bit && !i_bus.bus_busy |=> state_reg == ST_OFF)
        else $error("drain did not end");

    a_flag_follows: assert property (@(posedge i_clock) disable iff (i_rst)
        is_running(state_reg) |=> o_enable_state_flag)
        else $error("flag off while running");

    a_flag_off_wake: assert property (@(posedge i_clock) disable iff (i_rst)
        state_reg == ST_WAKE |=> !o_enable_state_flag)
        else $error("flag on during wake");

    // Assertions: register and request bits
    a_reset_clears_reg: assert property (@(posedge i_clock)
        i_rst |=> gcon_reg == `GCON_RESET && o_general_control_reg == `GCON_RESET)
        else $error("register not cleared by reset");

    a_write_lands: assert property (@(posedge i_clock) disable iff (i_rst)
        i_wr.wr |=> gcon_reg == $past(i_wr.data))
        else $error("write lost");

    a_readback_follows: assert property (@(posedge i_clock) disable iff (i_rst)
        i_wr.wr |=> ##1 o_general_control_reg == $past(gcon_reg))
        else $error("readback stale");

    a_controller_soft_reset_clears: assert property (@(posedge i_clock) disable iff (i_rst)
        gcon_reg[`GCON_BIT_CONTROLLER_SOFT_RESET] && !i_wr.wr |=> !gcon_reg[`GCON_BIT_CONTROLLER_SOFT_RESET])
        else $error("soft reset stuck");

    a_soft_reset_out: assert property (@(posedge i_clock) disable iff (i_rst)
        gcon_reg[`GCON_BIT_CONTROLLER_SOFT_RESET] |=> o_ctrl_soft_reset)
        else $error("soft reset not issued");

    a_ovld_clears: assert property (@(posedge i_clock) disable iff (i_rst)
        i_bus.ovld_start && !i_wr.wr |=> !gcon_reg[`GCON_BIT_OVLD])
        else $error("overload request stuck");

    a_ovld_out: assert property (@(posedge i_clock) disable iff (i_rst)
        gcon_reg[`GCON_BIT_OVLD] |=> o_overload_frame_request)
        else $error("overload request not shown");

    a_listen_copy: assert property (@(posedge i_clock) disable iff (i_rst)
        gcon_reg[`GCON_BIT_LISTEN] |=> o_listen_mode)
        else $error("listening mode not shown");

    // Assertions: time-triggered capture
    a_tt_ignored: assert property (@(posedge i_clock) disable iff (i_rst)
        !gcon_reg[`GCON_BIT_TTC] |=> !o_tt_capture)
        else $error("capture outside tt mode");

    a_tt_point: assert property (@(posedge i_clock) disable iff (i_rst)
        gcon_reg[`GCON_BIT_TTC] && gcon_reg[`GCON_BIT_SYNC] && i_bus.eof_last |=> o_tt_capture)
        else $error("eof capture missed");

    a_sof_point: assert property (@(posedge i_clock) disable iff (i_rst)
        gcon_reg[`GCON_BIT_TTC] && !gcon_reg[`GCON_BIT_SYNC] && i_bus.sof |=> o_tt_capture)
        else $error("sof capture missed");
endmodule : can_general_control
`default_nettype wire

/* can_general_control_tb.sv */
`default_nettype none
module can_general_control_tb;
    import can_gen_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock, i_rst, i_engine_txd, flag, clk_en, run, rx_en, txd, srst, overload_frame_request, cap;
    reg_write_t i_wr;
    bus_event_t bus;
    logic [7:0] rdbk, v;
    logic lst;
    logic [31:0] seed = 32'h2;
    int err_count, samples_checked, early, late;
    logic [7:0] cfg[3] = '{8'h22, 8'h32, 8'h12};
    logic [7:0] ex[3] = '{8'h10, 8'h01, 8'h00};
    can_general_control DUT (.i_clock(i_clock), .i_rst(i_rst), .i_wr(i_wr),
        .o_general_control_reg(rdbk), .o_enable_state_flag(flag), .i_bus(bus),
        .i_engine_txd(i_engine_txd), .o_ctrl_clk_en(clk_en), .o_ctrl_run(run),
        .o_rx_enable(rx_en), .o_txd(txd), .o_ctrl_soft_reset(srst),
        .o_overload_frame_request(overload_frame_request), .o_listen_mode(lst), .o_tt_capture(cap));
    can_bus_node node (.i_clock(i_clock), .o_bus(bus));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Readback after a write: the soft reset bit never stays set
    function automatic logic [7:0] rb(input logic [7:0] d);
        return d & 8'hfe;
    endfunction : rb
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic tic(input int n);
        repeat (n) @(negedge i_clock);
    endtask : tic
    task automatic wr(input logic [7:0] d);
        @(negedge i_clock) i_wr <= {1'b1, d};
        @(negedge i_clock) i_wr <= '0;
    endtask : wr
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // 250 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    // Watchdog, far beyond the roughly 110 cycles the run needs
    initial begin
        #40000;
        err_count++;
        wrap_up();
    end
    // Main sequence, inputs moved on falling edges only
    initial begin
        i_rst = 1'b1;
        i_wr = '0;
        i_engine_txd = 1'b1;
        tic(6);
        i_rst <= 1'b0;
        chk(rdbk, 8'h00, "reset reg");
        chk({flag, run, clk_en, txd}, 8'h01, "reset outs");
        wr(8'h02);
        tic(3);
        chk(run, 8'h00, "early run");
        tic(1);
        chk({run, flag, clk_en, rx_en}, 8'h0f, "enabled");
        i_engine_txd <= 1'b0;
        tic(2);
        chk(txd, 8'h00, "tx follows engine");
        i_engine_txd <= 1'b1;
        $display("test enable done");
        for (int i = 0; i < 3; i++) begin
            wr(cfg[i]);
            early = 0;
            late = 0;
            fork
                node.frame(6, 1'b0);
                for (int k = 0; k < 12; k++) begin
                    @(negedge i_clock);
                    if (cap === 1'b1 && k < 4) early++;
                    else if (cap === 1'b1) late++;
                end
            join
            chk(8'(early * 16 + late), ex[i], "capture point");
        end
        $display("test capture done");
        wr(8'h42);
        tic(1);
        chk(overload_frame_request, 8'h01, "ovld set");
        node.frame(4, 1'b1);
        tic(2);
        chk({overload_frame_request, rdbk[6]}, 8'h00, "ovld clear");
        wr(8'h03);
        early = (srst === 1'b1);
        for (int k = 0; k < 3; k++) begin
            tic(1);
            early += (srst === 1'b1);
        end
        chk(8'(early), 8'h01, "soft reset pulse");
        chk(rdbk, rb(8'h03), "soft reset clear");
        $display("test ovld and reset done");
        fork
            node.frame(12, 1'b0);
            begin
                tic(2);
                wr(8'h00);
                tic(3);
                chk(run, 8'h01, "drain run");
            end
        join
        tic(3);
        chk({run, flag, clk_en, rx_en, txd}, 8'h01, "standby");
        repeat (4) begin
            seed = xs(seed);
            v = seed[7:0] & 8'hbd;
            i_engine_txd <= seed[8];
            wr(v);
            tic(2);
            chk(rdbk, rb(v), "disabled access");
            chk(lst, v[3], "listen");
            chk(txd, 8'h01, "recessive");
        end
        $display("test standby done");
        wrap_up();
    end
endmodule : can_general_control_tb
`default_nettype wire
